// ---- src/evport_params.svh ----
// Constants for the coprocessor event port and its transfer controller
`ifndef EVPORT_PARAMS_SVH
`define EVPORT_PARAMS_SVH
`define CFG_WORDS       12
`define CFG_IDX_W       4
`define OUTP_ELEMS      18'h00002
`define CNT_W           18
`define DATA_W          32
`define LEN_LSB         0
`define LEN_W           16
`define MODE_SHARED_BIT 16
`define RATE_LSB        17
`define RATE_W          2
`define TABLE_BIT       19
`define PARAM_BIT       20
`define RATE_QUARTER    2'h2
`define REG_AW          8
`define REG_EXEC        8'h00
`define REG_STATUS      8'h04
`define REG_IRQ_STAT    8'h08
`define REG_IRQ_MASK    8'h0c
`define REG_FRAME       8'h10
`define EXEC_START_BIT  0
`define IRQ_W           2
`define IRQ_FRAME_DONE  0
`define IRQ_START_REFUSED 1
`endif

// ---- src/evport_pkg.sv ----
// Types shared by both ends of the event port
`default_nettype none
`include "evport_params.svh"
package evport_pkg;
  typedef enum logic [2:0] {
    SET_CFG   = 3'h0,
    SET_SP    = 3'h1,
    SET_AP    = 3'h2,
    SET_TABLE = 3'h3,
    SET_HD    = 3'h4,
    SET_OUTP  = 3'h5,
    SET_EXT   = 3'h6
  } data_set_t;

  typedef enum logic [7:0] {
    ST_IDLE     = 8'h01,
    ST_IN_CFG   = 8'h02,
    ST_IN_SP    = 8'h04,
    ST_IN_AP    = 8'h08,
    ST_IN_TABLE = 8'h10,
    ST_DECODE   = 8'h20,
    ST_OUT_MAIN = 8'h40,
    ST_OUT_PAR  = 8'h80
  } dev_state_t;

  typedef enum logic [2:0] {
    DMA_IDLE  = 3'h1,
    DMA_WRITE = 3'h2,
    DMA_READ  = 3'h4
  } dma_state_t;

  typedef struct packed {
    dev_state_t                            state;
    logic                                  fire;
    logic [`CNT_W-1:0]                     remaining;
    logic [`CFG_WORDS-1:0][`DATA_W-1:0]    cfg;
    logic [`CFG_IDX_W-1:0]                 cfg_idx;
    data_set_t                             evt_set;
    logic [`CNT_W-1:0]                     evt_count;
    logic                                  evt_last;
    logic [`DATA_W-1:0]                    rdata;
    logic                                  core_valid;
    data_set_t                             core_set;
    logic [`DATA_W-1:0]                    core_data;
    logic                                  core_start;
    logic [`IRQ_W-1:0]                     irq_stat;
    logic [`IRQ_W-1:0]                     irq_mask;
    logic [`DATA_W-1:0]                    reg_rdata;
  } dev_regs_t;

  typedef struct packed {
    dma_state_t          state;
    data_set_t           set;
    logic [`CNT_W-1:0]   left;
    logic                last;
    logic                wr;
    logic [`DATA_W-1:0]  wdata;
    logic                rd;
    logic                rd_d;
    logic                rd_last_d;
    logic                dst_valid;
    data_set_t           dst_set;
    logic [`DATA_W-1:0]  dst_data;
    logic                done_irq;
  } dma_regs_t;
endpackage
`default_nettype wire

// ---- src/evport_if.sv ----
// Event and element link between the coprocessor port and the transfer controller
`default_nettype none
`include "evport_params.svh"
interface evport_if;
  logic                   input_request_event;
  logic                   readout_event;
  evport_pkg::data_set_t  evt_set;
  logic [`CNT_W-1:0]      evt_count;
  logic                   evt_last;
  logic                   elem_wr;
  logic [`DATA_W-1:0]     elem_wdata;
  logic                   elem_rd;
  logic [`DATA_W-1:0]     elem_rdata;

  modport device (
    output input_request_event, readout_event, evt_set, evt_count, evt_last, elem_rdata,
    input  elem_wr, elem_wdata, elem_rd
  );
  modport dma (
    input  input_request_event, readout_event, evt_set, evt_count, evt_last, elem_rdata,
    output elem_wr, elem_wdata, elem_rd
  );
endinterface
`default_nettype wire

// ---- src/evport_dma.sv ----
// Transfer controller end: services events between host buffers and the coprocessor
`default_nettype none
`include "evport_params.svh"
module evport_dma (
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  // Link
  evport_if.dma                      link,
  // Source buffer side
  output logic                       src_take_out,
  output logic [2:0]                 src_set_out,
  input  wire logic [`DATA_W-1:0]    src_data_in,
  // Destination buffer side
  output logic                       dst_valid_out,
  output logic [2:0]                 dst_set_out,
  output logic [`DATA_W-1:0]         dst_data_out,
  // Completion interrupt
  output logic                       done_irq_out,
  input  wire logic                  irq_clear_in
);
  evport_pkg::dma_regs_t q_reg;
  evport_pkg::dma_regs_t q_next;
  logic                  moving;

  // Source data must be valid whenever take is high
  assign moving        = (q_reg.left != '0);
  assign src_take_out  = (q_reg.state == evport_pkg::DMA_WRITE) && moving;
  assign src_set_out   = q_reg.set;
  assign link.elem_wr    = q_reg.wr;
  assign link.elem_wdata = q_reg.wdata;
  assign link.elem_rd    = q_reg.rd;
  assign dst_valid_out = q_reg.dst_valid;
  assign dst_set_out   = q_reg.dst_set;
  assign dst_data_out  = q_reg.dst_data;
  assign done_irq_out  = q_reg.done_irq;

  always_comb
  begin
    q_next           = q_reg;
    q_next.wr        = 1'b0;
    q_next.rd        = 1'b0;
    q_next.rd_d      = q_reg.rd;
    q_next.rd_last_d = 1'b0;
    q_next.dst_valid = 1'b0;
    case (q_reg.state)
      evport_pkg::DMA_IDLE:
      begin
        if (link.input_request_event)
        begin
          q_next.state = evport_pkg::DMA_WRITE;
          q_next.set   = link.evt_set;
          q_next.left  = link.evt_count;
          q_next.last  = 1'b0;
        end
        else if (link.readout_event)
        begin
          q_next.state = evport_pkg::DMA_READ;
          q_next.set   = link.evt_set;
          q_next.left  = link.evt_count;
          q_next.last  = link.evt_last;
        end
      end
      evport_pkg::DMA_WRITE:
      begin
        if (moving)
        begin
          q_next.wr    = 1'b1;
          q_next.wdata = src_data_in;
          q_next.left  = q_reg.left - 1'b1;
        end
        else
        begin
          q_next.state = evport_pkg::DMA_IDLE;
        end
      end
      evport_pkg::DMA_READ:
      begin
        if (moving)
        begin
          q_next.rd        = 1'b1;
          q_next.left      = q_reg.left - 1'b1;
        end
        else
        begin
          q_next.state = evport_pkg::DMA_IDLE;
        end
        q_next.rd_last_d = q_reg.rd && !moving && q_reg.last;
      end
      default:
      begin
        q_next.state = evport_pkg::DMA_IDLE;
      end
    endcase
    // Read data stands one cycle after the strobe
    if (q_reg.rd_d)
    begin
      q_next.dst_valid = 1'b1;
      q_next.dst_set   = q_reg.set;
      q_next.dst_data  = link.elem_rdata;
    end
    // Final element of the last readout is done; set wins over clear
    q_next.done_irq = (q_reg.done_irq && !irq_clear_in) || (q_reg.rd_d && q_reg.rd_last_d); // [RULE9]
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      q_reg       <= '0;
      q_reg.state <= evport_pkg::DMA_IDLE;
    end
    else
    begin
      q_reg <= q_next;
    end
  end
endmodule
`default_nettype wire

// ---- src/evport_device.sv ----
// Coprocessor end: raises input and readout events and moves elements to and from the core
// How it works
// [RULE1] Hard decisions leave packed in 64-bit words
// [RULE2] Output parameters: one 64-bit word, two elements
// [RULE3] Twelve configuration words arrive after start
// [RULE4] Readout events for output, input events for input
// [RULE5] Standalone: own event series per data set
// [RULE6] Input order: config, soft values, optional table
// [RULE7] Output: hard decisions, then optional parameter word
// [RULE8] Start command triggers first configuration request
// [RULE9] Controller interrupts after the final readout transfer
// [RULE10] Shared mode: single constituent decoder only
// [RULE11] Shared mode soft value and a-priori counts
// [RULE12] Soft values are 8-bit signed bytes
// [RULE13] Shared mode: extrinsic bytes, 8-byte rounded buffer
// [RULE14] Buffers sit on 64-bit boundaries
// [RULE15] Cleared table flag reuses the stored table
// [RULE16] Table: one 16-bit index per bit
// [RULE17] Next data set only after full count moved
`default_nettype none
`include "evport_params.svh"
module evport_device (
  // Clock and reset
  input  wire logic                            clk_in,
  input  wire logic                            rst_n_in,
  // Link
  evport_if.device                             link,
  // Register port
  input  wire logic [`REG_AW-1:0]              reg_addr_in,
  input  wire logic [`DATA_W-1:0]              reg_wdata_in,
  input  wire logic                            reg_wr_in,
  input  wire logic                            reg_rd_in,
  output logic [`DATA_W-1:0]                   reg_rdata_out,
  output logic                                 irq_out,
  // Decoder core side
  output logic [`CFG_WORDS*`DATA_W-1:0]        cfg_words_out,
  output logic                                 core_valid_out,
  output logic [2:0]                           core_set_out,
  output logic [`DATA_W-1:0]                   core_data_out,
  output logic                                 core_start_out,
  input  wire logic                            core_done_in,
  output logic                                 core_rd_out,
  input  wire logic [`DATA_W-1:0]              core_rd_data_in
);
  evport_pkg::dev_regs_t q_reg;
  evport_pkg::dev_regs_t q_next;
  logic                  shared_mode;
  logic                  table_flag;
  logic                  param_flag;
  logic                  in_state;
  logic                  out_state;
  logic                  take_wr;
  logic                  take_rd;
  logic                  start_cmd;
  logic [`IRQ_W-1:0]     irq_evt;

  // Two 32-bit elements per 64-bit word, so counts are always even
  function automatic logic [`CNT_W-1:0] elems_for_bytes(input logic [`CNT_W+1:0] bytes);
    logic [`CNT_W+1:0] words;
    words = (bytes + 20'h00007) >> 3;
    return {words[`CNT_W-2:0], 1'b0}; // [RULE14]
  endfunction

  // Element count of each data set, from the stored frame settings
  function automatic logic [`CNT_W-1:0] count_for(input evport_pkg::data_set_t s,
                                                   input logic [`DATA_W-1:0] w0);
    logic [`CNT_W+1:0] f;
    logic [`CNT_W+1:0] r;
    logic [`CNT_W+1:0] b;
    f = {4'h0, w0[`LEN_LSB +: `LEN_W]};
    r = {18'h00000, w0[`RATE_LSB +: `RATE_W]} + 20'h00002;
    case (s)
      evport_pkg::SET_CFG:   b = 20'h00000;
      evport_pkg::SET_SP:
      begin
        if (!w0[`MODE_SHARED_BIT])
          b = (20'(f * r));
        else if (w0[`RATE_LSB +: `RATE_W] == `RATE_QUARTER)
          b = (20'(f * 20'h00005) + 20'h00001) >> 1; // [RULE11]
        else
          b = f << 1; // [RULE11]
      end
      evport_pkg::SET_AP:    b = f; // [RULE11]
      evport_pkg::SET_TABLE: b = f << 1; // [RULE16]
      evport_pkg::SET_HD:    b = ((f + 20'h0003f) >> 6) << 3; // [RULE1]
      evport_pkg::SET_EXT:   b = f; // [RULE13]
      default:               b = 20'h00000;
    endcase
    if (s == evport_pkg::SET_CFG)
      return 18'(`CFG_WORDS); // [RULE3]
    else if (s == evport_pkg::SET_OUTP)
      return `OUTP_ELEMS; // [RULE2]
    else
      return elems_for_bytes(b);
  endfunction

  assign shared_mode = q_reg.cfg[0][`MODE_SHARED_BIT];
  assign table_flag  = q_reg.cfg[0][`TABLE_BIT];
  assign param_flag  = q_reg.cfg[0][`PARAM_BIT];
  assign in_state    = (q_reg.state == evport_pkg::ST_IN_CFG) ||
                       (q_reg.state == evport_pkg::ST_IN_SP) ||
                       (q_reg.state == evport_pkg::ST_IN_AP) ||
                       (q_reg.state == evport_pkg::ST_IN_TABLE);
  assign out_state   = (q_reg.state == evport_pkg::ST_OUT_MAIN) ||
                       (q_reg.state == evport_pkg::ST_OUT_PAR);
  // Strays outside a request or past its count are dropped
  assign take_wr     = link.elem_wr && in_state && !q_reg.fire && (q_reg.remaining != '0);
  assign take_rd     = link.elem_rd && out_state && !q_reg.fire && (q_reg.remaining != '0);
  assign start_cmd   = reg_wr_in && (reg_addr_in == `REG_EXEC) &&
                       reg_wdata_in[`EXEC_START_BIT];

  assign link.input_request_event = q_reg.fire && in_state; // [RULE4]
  assign link.readout_event       = q_reg.fire && out_state; // [RULE4]
  assign link.evt_set    = q_reg.evt_set;
  assign link.evt_count  = q_reg.evt_count;
  assign link.evt_last   = q_reg.evt_last;
  assign link.elem_rdata = q_reg.rdata;
  assign core_rd_out     = take_rd;
  assign core_valid_out  = q_reg.core_valid;
  assign core_set_out    = q_reg.core_set;
  assign core_data_out   = q_reg.core_data;
  assign core_start_out  = q_reg.core_start;
  assign cfg_words_out   = q_reg.cfg;
  assign reg_rdata_out   = q_reg.reg_rdata;
  assign irq_out         = |(q_reg.irq_stat & q_reg.irq_mask);

  always_comb
  begin
    q_next            = q_reg;
    q_next.core_valid = 1'b0;
    q_next.core_start = 1'b0;
    q_next.fire       = 1'b0;
    q_next.rdata      = '0;
    irq_evt           = '0;
    if (take_wr)
    begin
      q_next.remaining  = q_reg.remaining - 1'b1;
      q_next.core_valid = 1'b1;
      q_next.core_set   = q_reg.evt_set;
      q_next.core_data  = link.elem_wdata; // [RULE12]
      if (q_reg.state == evport_pkg::ST_IN_CFG)
      begin
        q_next.cfg[q_reg.cfg_idx] = link.elem_wdata; // [RULE3]
        q_next.cfg_idx            = q_reg.cfg_idx + 1'b1;
      end
    end
    if (take_rd)
    begin
      q_next.remaining = q_reg.remaining - 1'b1;
      q_next.rdata     = core_rd_data_in;
    end
    // Fire stays high one cycle, then the count runs out before moving on
    if (!q_reg.fire && (q_next.remaining == '0)) // [RULE17]
    begin
      case (q_reg.state)
        evport_pkg::ST_IDLE:
        begin
          if (start_cmd)
          begin
            q_next.state   = evport_pkg::ST_IN_CFG; // [RULE8]
            q_next.evt_set = evport_pkg::SET_CFG;
            q_next.cfg_idx = '0;
          end
        end
        evport_pkg::ST_IN_CFG:
        begin
          q_next.state   = evport_pkg::ST_IN_SP; // [RULE6]
          q_next.evt_set = evport_pkg::SET_SP;
        end
        evport_pkg::ST_IN_SP:
        begin
          if (q_next.cfg[0][`MODE_SHARED_BIT])
          begin
            q_next.state   = evport_pkg::ST_IN_AP; // [RULE10]
            q_next.evt_set = evport_pkg::SET_AP;
          end
          else if (table_flag)
          begin
            q_next.state   = evport_pkg::ST_IN_TABLE; // [RULE6]
            q_next.evt_set = evport_pkg::SET_TABLE;
          end
          else
          begin
            // Core keeps the previous table
            q_next.state      = evport_pkg::ST_DECODE; // [RULE15]
            q_next.core_start = 1'b1;
          end
        end
        evport_pkg::ST_IN_AP, evport_pkg::ST_IN_TABLE:
        begin
          q_next.state      = evport_pkg::ST_DECODE;
          q_next.core_start = 1'b1;
        end
        evport_pkg::ST_DECODE:
        begin
          if (core_done_in)
          begin
            q_next.state   = evport_pkg::ST_OUT_MAIN; // [RULE7]
            // No on-chip hard decisions in shared mode
            q_next.evt_set = shared_mode ? evport_pkg::SET_EXT : evport_pkg::SET_HD; // [RULE10]
          end
        end
        evport_pkg::ST_OUT_MAIN:
        begin
          if (!shared_mode && param_flag)
          begin
            q_next.state   = evport_pkg::ST_OUT_PAR; // [RULE7]
            q_next.evt_set = evport_pkg::SET_OUTP;
          end
          else
          begin
            q_next.state = evport_pkg::ST_IDLE;
            irq_evt[`IRQ_FRAME_DONE] = 1'b1;
          end
        end
        evport_pkg::ST_OUT_PAR:
        begin
          q_next.state = evport_pkg::ST_IDLE;
          irq_evt[`IRQ_FRAME_DONE] = 1'b1;
        end
        default:
        begin
          q_next.state = evport_pkg::ST_IDLE;
        end
      endcase
      if (q_next.state != q_reg.state && q_next.state != evport_pkg::ST_IDLE &&
          q_next.state != evport_pkg::ST_DECODE)
      begin
        // One event series per data set
        q_next.fire      = 1'b1; // [RULE5]
        q_next.evt_count = count_for(q_next.evt_set, q_next.cfg[0]);
        q_next.remaining = q_next.evt_count;
        q_next.evt_last  = (q_next.state == evport_pkg::ST_OUT_PAR) ||
                           ((q_next.state == evport_pkg::ST_OUT_MAIN) &&
                            (shared_mode || !param_flag)); // [RULE9]
      end
    end
    if (start_cmd && (q_reg.state != evport_pkg::ST_IDLE))
      irq_evt[`IRQ_START_REFUSED] = 1'b1;
    // Register port; an interrupt status read clears, a new event in that cycle still sets
    q_next.reg_rdata = '0;
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        `REG_STATUS:   q_next.reg_rdata = {23'h000000, q_reg.fire, q_reg.state};
        `REG_IRQ_STAT: q_next.reg_rdata = {30'h00000000, q_reg.irq_stat};
        `REG_IRQ_MASK: q_next.reg_rdata = {30'h00000000, q_reg.irq_mask};
        `REG_FRAME:    q_next.reg_rdata = q_reg.cfg[0];
        default:       q_next.reg_rdata = '0;
      endcase
    end
    if (reg_wr_in && (reg_addr_in == `REG_IRQ_MASK))
      q_next.irq_mask = reg_wdata_in[`IRQ_W-1:0];
    q_next.irq_stat = ((reg_rd_in && (reg_addr_in == `REG_IRQ_STAT)) ? '0 : q_reg.irq_stat) |
                      irq_evt;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      q_reg         <= '0;
      q_reg.state   <= evport_pkg::ST_IDLE;
    end
    else
    begin
      q_reg <= q_next;
    end
  end
endmodule
`default_nettype wire

// ---- dv/evport_assertions.sv ----
// Concurrent checks on the event link between both ends
`default_nettype none
`include "evport_params.svh"
module evport_assertions (
  // Clock and reset
  input wire logic                 clk_in,
  input wire logic                 rst_n_in,
  // Link
  input wire logic                 input_request_event,
  input wire logic                 readout_event,
  input var evport_pkg::data_set_t evt_set,
  input wire logic [`CNT_W-1:0]    evt_count,
  input wire logic                 evt_last,
  input wire logic                 elem_wr,
  input wire logic                 elem_rd
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  wire any_evt = input_request_event || readout_event;

  sequence s_cfg_evt;
    input_request_event && evt_set == evport_pkg::SET_CFG;
  endsequence
  // Twelve back-to-back writes, split since repetition stays small
  sequence s_cfg_moved;
    elem_wr [*8] ##1 elem_wr [*4];
  endsequence
  sequence s_sp_evt;
    input_request_event && evt_set == evport_pkg::SET_SP;
  endsequence

  property p_cfg_count; s_cfg_evt |-> evt_count == 18'h0000c; endproperty
  a_cfg_count: assert property (p_cfg_count) else $error("config count wrong");
  property p_cfg_then_sp; s_cfg_evt |-> ##2 s_cfg_moved ##1 s_sp_evt; endproperty
  a_cfg_then_sp: assert property (p_cfg_then_sp) else $error("config not followed");
  property p_in_sets; input_request_event |-> evt_set <= evport_pkg::SET_TABLE; endproperty
  a_in_sets: assert property (p_in_sets) else $error("input event on output set");
  property p_out_sets; readout_event |-> evt_set >= evport_pkg::SET_HD; endproperty
  a_out_sets: assert property (p_out_sets) else $error("readout on input set");
  property p_outp_word;
    readout_event && evt_set == evport_pkg::SET_OUTP |-> evt_count == `OUTP_ELEMS && evt_last;
  endproperty
  a_outp_word: assert property (p_outp_word) else $error("parameter word wrong");
  property p_even; any_evt |-> !evt_count[0]; endproperty
  a_even: assert property (p_even) else $error("odd element count");
  property p_wr_walk; input_request_event && evt_count != 18'h0 |-> ##2 elem_wr; endproperty
  a_wr_walk: assert property (p_wr_walk) else $error("input transfer late");
  property p_rd_walk; readout_event && evt_count != 18'h0 |-> ##2 elem_rd; endproperty
  a_rd_walk: assert property (p_rd_walk) else $error("readout transfer late");
  property p_no_evt_mid; elem_wr || elem_rd |-> !any_evt; endproperty
  a_no_evt_mid: assert property (p_no_evt_mid) else $error("event during transfer");
  property p_ext_last; readout_event && evt_set == evport_pkg::SET_EXT |-> evt_last; endproperty
  a_ext_last: assert property (p_ext_last) else $error("extrinsic not final");
  property p_evt_pulse; any_evt && evt_count != 18'h0 |=> !any_evt; endproperty
  a_evt_pulse: assert property (p_evt_pulse) else $error("event longer than a cycle");
endmodule
`default_nettype wire

// ---- dv/tb_turbo_decoder_dma_event_port.sv ----
// Self-checking bench joining the coprocessor port to its transfer controller
`default_nettype none
`include "evport_params.svh"
module tb_turbo_decoder_dma_event_port;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] all_bits = 32'hffffffff;
  // Stimulus
  logic              clk_in = 1'b0;
  logic              rst_n_in = 1'b0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic              core_done = 1'b0;
  logic              irq_clear = 1'b0;
  logic [7:0]        reg_addr = 8'h00;
  logic [31:0]       reg_wdata = 32'h0;
  logic [31:0]       core_rd_data = 32'h0;
  logic [31:0]       src_data = 32'h0;
  // Observed
  logic [31:0]       reg_rdata;
  logic [31:0]       dst_data, core_data;
  logic [383:0]      cfg_words;
  logic [2:0]        core_set;
  logic [2:0]        dst_set;
  logic              irq, core_valid, core_start, core_rd, src_take, dst_valid, done_irq;
  // Bookkeeping
  int                error_cnt = 0;
  int                samples_checked = 0;
  int                cycles = 0;
  int                src_n, rd_n, dst_n;
  int                core_cnt [8];
  int                dst_cnt [8];
  int                ec [$];
  logic [2:0]        seq [$];
  logic [2:0]        es [$];
  logic [`CNT_W-1:0] cnt_q [$];
  logic [31:0]       src_q [$];

  always #25 clk_in = ~clk_in;

  evport_if link_if ();
  evport_device evport_device_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .link(link_if),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .irq_out(irq),
    .cfg_words_out(cfg_words), .core_valid_out(core_valid), .core_set_out(core_set),
    .core_data_out(core_data), .core_start_out(core_start), .core_done_in(core_done),
    .core_rd_out(core_rd), .core_rd_data_in(core_rd_data));
  evport_dma evport_dma_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .link(link_if),
    .src_take_out(src_take), .src_set_out(), .src_data_in(src_data),
    .dst_valid_out(dst_valid), .dst_set_out(dst_set), .dst_data_out(dst_data),
    .done_irq_out(done_irq), .irq_clear_in(irq_clear));
  evport_assertions evport_assertions_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .input_request_event(link_if.input_request_event), .readout_event(link_if.readout_event),
    .evt_set(link_if.evt_set), .evt_count(link_if.evt_count), .evt_last(link_if.evt_last),
    .elem_wr(link_if.elem_wr), .elem_rd(link_if.elem_rd));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("mismatches %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Source and core answer with a running pattern so every element is traceable
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (link_if.input_request_event || link_if.readout_event)
    begin
      seq.push_back(link_if.evt_set);
      cnt_q.push_back(link_if.evt_count);
    end
    if (core_valid)
    begin
      core_cnt[core_set]++;
      check(core_data, src_q.pop_front());
    end
    if (dst_valid)
    begin
      dst_cnt[dst_set]++;
      check(dst_data, 32'hd0000000 + dst_n);
      dst_n++;
    end
    if (src_take)
    begin
      src_q.push_back(src_data);
      src_n++;
      src_data <= 32'h10000000 + src_n;
    end
    if (core_rd)
    begin
      rd_n++;
      core_rd_data <= 32'hd0000000 + rd_n;
    end
    if (cycles == 20000)
    begin
      error_cnt++;
      test_done();
    end
  end

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_in);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_in);
    reg_rd <= 1'b0;
    #1 check(reg_rdata & m, e);
  endtask

  task automatic exp_add(input logic [2:0] s, input int n);
    es.push_back(s);
    ec.push_back(n);
  endtask

  function automatic int el(input int b);
    return 2 * ((b + 7) / 8);
  endfunction

  task automatic run_frame(input logic [31:0] w0, input logic refuse, input logic [1:0] mask);
    int len;
    int r;
    len = int'(w0[15:0]);
    r = int'(w0[18:17]);
    seq.delete();
    cnt_q.delete();
    src_q.delete();
    es.delete();
    ec.delete();
    src_n = 0;
    rd_n = 0;
    dst_n = 0;
    core_cnt = '{default: 0};
    dst_cnt = '{default: 0};
    exp_add(evport_pkg::SET_CFG, `CFG_WORDS);
    if (w0[`MODE_SHARED_BIT])
    begin
      exp_add(evport_pkg::SET_SP, el(r == 2 ? (5 * len + 1) / 2 : 2 * len));
      exp_add(evport_pkg::SET_AP, el(len));
      exp_add(evport_pkg::SET_EXT, el(len));
    end
    else
    begin
      exp_add(evport_pkg::SET_SP, el(len * (r + 2)));
      if (w0[`TABLE_BIT]) exp_add(evport_pkg::SET_TABLE, el(2 * len));
      exp_add(evport_pkg::SET_HD, el(8 * ((len + 63) / 64)));
      if (w0[`PARAM_BIT]) exp_add(evport_pkg::SET_OUTP, 2);
    end
    src_data <= w0;
    core_rd_data <= 32'hd0000000;
    reg_write(`REG_IRQ_MASK, {30'h0, mask});
    reg_write(`REG_EXEC, 32'h1);
    #1 check(link_if.input_request_event, 1'b1);
    check(link_if.evt_count, `CFG_WORDS);
    if (refuse) reg_write(`REG_EXEC, 32'h1);
    repeat (3000) if (core_start !== 1'b1) @(posedge clk_in) #1;
    check(cfg_words[31:0], w0);
    check(cfg_words[383:352], 32'h1000000b);
    rd_chk(`REG_FRAME, all_bits, w0);
    @(posedge clk_in);
    core_done <= 1'b1;
    @(posedge clk_in);
    core_done <= 1'b0;
    repeat (3000) if (done_irq !== 1'b1) @(posedge clk_in) #1;
    // Last destination pulse rises in the same cycle as the completion flag
    repeat (3) @(posedge clk_in);
    #1 check(seq.size(), es.size());
    foreach (es[i])
    begin
      check(seq[i], es[i]);
      check(cnt_q[i], ec[i]);
      if (es[i] >= 3'h4) check(dst_cnt[es[i]], ec[i]);
      else if (es[i] != 3'h0) check(core_cnt[es[i]], ec[i]);
    end
    check(done_irq, 1'b1);
    check(irq, |(mask & {refuse, 1'b1}));
    rd_chk(`REG_IRQ_STAT, all_bits, {30'h0, refuse, 1'b1});
    check(irq, 1'b0);
    rd_chk(`REG_STATUS, 32'h000000ff, 32'h00000001);
    @(posedge clk_in);
    irq_clear <= 1'b1;
    @(posedge clk_in);
    irq_clear <= 1'b0;
    #1 check(done_irq, 1'b0);
  endtask

  task automatic t_regs();
    rd_chk(`REG_IRQ_MASK, all_bits, 32'h0);
    rd_chk(`REG_STATUS, 32'h000000ff, 32'h00000001);
    reg_write(8'h40, all_bits);
    rd_chk(8'h40, all_bits, 32'h0);
    reg_write(`REG_IRQ_MASK, 32'h3);
    rd_chk(`REG_IRQ_MASK, all_bits, 32'h3);
  endtask

  // Frame length 70, quarter rate, table and parameter word, start repeated while busy
  task automatic t_alone_full();
    run_frame(32'h001c0046, 1'b1, 2'h3);
  endtask

  // Frame length 64 at third rate, stored table reused, parameter word, interrupt masked
  task automatic t_alone_reuse();
    run_frame(32'h00120040, 1'b0, 2'h0);
  endtask

  task automatic t_shared_quarter();
    run_frame(32'h0005000d, 1'b0, 2'h1);
  endtask

  task automatic t_shared_third();
    run_frame(32'h00030008, 1'b0, 2'h1);
  endtask

  initial
  begin
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_alone_full();
    t_alone_reuse();
    t_shared_quarter();
    t_shared_third();
    test_done();
  end
endmodule
`default_nettype wire
